// [design/acst_cfg.svh]
// register offsets, field positions and reset values for the self-test block
`ifndef ACST_CFG_SVH
`define ACST_CFG_SVH
// one register per aligned word: the byte address is four times the index
`define ACST_IDX_FILTER_CONTROL 10'h02c
`define ACST_IDX_POWER_CONTROL 10'h02d
`define ACST_IDX_DIAG_CONTROL 10'h02e
`define ACST_IDX_STATUS 10'h030
`define ACST_IDX_STIM_LEVEL 10'h034
`define ACST_OFF_FILTER_CONTROL {`ACST_IDX_FILTER_CONTROL, 2'b00}
`define ACST_OFF_POWER_CONTROL {`ACST_IDX_POWER_CONTROL, 2'b00}
`define ACST_OFF_DIAG_CONTROL {`ACST_IDX_DIAG_CONTROL, 2'b00}
`define ACST_OFF_STATUS {`ACST_IDX_STATUS, 2'b00}
`define ACST_OFF_STIM_LEVEL {`ACST_IDX_STIM_LEVEL, 2'b00}
// bit positions of the one-hot register select
`define ACST_SEL_FILTER 0
`define ACST_SEL_POWER 1
`define ACST_SEL_DIAG 2
`define ACST_SEL_STATUS 3
`define ACST_SEL_STIM 4
`define ACST_SEL_W 5
`define ACST_ADDR_W 12
`define ACST_BIT_EXTERNAL_CLOCK_SELECT 6
`define ACST_BIT_DIAG_EN 0
`define ACST_BIT_REDUCED_BANDWIDTH_SELECT 4
`define ACST_BIT_RANGE_LO 6
`define ACST_BIT_RANGE_HI 7
`define ACST_RST_REG8 8'h00
`define ACST_RST_STIM 12'h0fa
`define ACST_RST_RANGE 2'h0
`define ACST_FULL_SCALE_2G 12'h7ff
`define ACST_FULL_SCALE_4G 12'h7ff
`define ACST_FULL_SCALE_8G 12'h7ff
`endif

// [design/acst_pkg.sv]
// types shared by the self-test and clock-select block
package acst_pkg;
  typedef struct packed {
    logic signed [11:0] x;
    logic signed [11:0] y;
    logic signed [11:0] z;
  } acst_axes_t;

  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } acst_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } acst_apb_rsp_t;

  typedef enum logic [1:0] {
    ACST_RANGE_2G,
    ACST_RANGE_4G,
    ACST_RANGE_8G,
    ACST_RANGE_RSVD
  } acst_range_t;
endpackage : acst_pkg

// [design/acst_self_test.sv]
// self-test stimulus, range saturation and external clock pin select
`timescale 1ns/1ps
`default_nettype none
`include "acst_cfg.svh"

// Summary of operation
// (RL1) The internal oscillator clocks the sensor unless software picks external clocking.
// (RL2) Setting bit 6 of the power control register turns interrupt pin one into a clock input.
// (RL3) Whoever drives that clock keeps it at or below 51.2 kHz.
// (RL4) The self-test stimulus is applied while the diagnostic enable bit is set and removed when cleared.
// (RL5) The host reads a baseline of all three axes before setting the enable bit.
// (RL6) The host waits four output data rate periods before reading the axes again.
// (RL7) The host subtracts baseline from test readings, scales to milli-g and checks every window.
// (RL8) The host ends the test by clearing the diagnostic enable bit.
// (RL9) Pass windows are 0.2 to 2.8 g for x and z and -2.8 to -0.2 g for y.
// (RL10) Self-test is best run in normal mode, widest range, 100 Hz rate, half bandwidth off.
// (RL11) The host averages 4 to 16 samples for both readings.
// (RL12) An axis beyond the selected range saturates at its full-scale code.
// (RL13) A pin used as clock input never signals interrupts.
// (RL14) The host keeps range, rate and noise mode fixed between baseline and test.
module acst_self_test #(
  parameter logic [11:0] STIM_RESET = `ACST_RST_STIM
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire acst_pkg::acst_apb_req_t apb_req,
  output acst_pkg::acst_apb_rsp_t apb_rsp,
  input wire acst_pkg::acst_axes_t raw_axes,
  input wire logic raw_valid,
  input wire logic irq_request,
  input wire logic first_interrupt_pin_in,
  output logic first_interrupt_pin_out,
  output logic first_interrupt_pin_oe_n,
  output logic sample_clock,
  output logic use_external_clock,
  output logic stimulus_on,
  output acst_pkg::acst_axes_t data_axes,
  output logic data_valid
);
  import acst_pkg::*;

  // each axis is one signed slice of the packed carrier, x on top
  localparam int AXIS_W = 12;
  localparam int N_AXES = 3;
  // y is the middle slice and is the axis that sees the offset negated
  localparam int NEG_AXIS = 1;

  logic [7:0] power_control_register_q;
  logic [7:0] diag_control_q;
  logic [7:0] filter_control_register_q;
  logic [11:0] stim_level_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic ext_sel;
  logic diag_on;
  logic access;
  logic done;
  logic [`ACST_SEL_W-1:0] sel;
  logic signed [11:0] fs_sel;
  logic [11:0] stim_pos;
  logic [11:0] stim_neg;
  logic [N_AXES*AXIS_W-1:0] raw_flat;
  logic signed [AXIS_W-1:0] axis_sum [N_AXES];

  // saturating add of a stimulus offset to one axis
  function automatic logic signed [11:0] sat_add(
    input logic signed [11:0] a,
    input logic signed [11:0] b,
    input logic signed [11:0] fs
  );
    logic signed [12:0] s;
    logic signed [12:0] lim;
    // one guard bit keeps the carry of an overflow visible to the clamp;
    // both sides stay signed so a negative sum is not read as huge
    s = 13'(a) + 13'(b);
    lim = 13'(fs);
    if (s > lim) begin
      sat_add = fs;
    end else if (s < -lim) begin
      sat_add = -fs;
    end else begin
      sat_add = s[11:0];
    end
  endfunction : sat_add

  function automatic logic signed [11:0] full_scale(input logic [1:0] r);
    case (acst_range_t'(r))
      ACST_RANGE_2G: full_scale = `ACST_FULL_SCALE_2G;
      ACST_RANGE_4G: full_scale = `ACST_FULL_SCALE_4G;
      default: full_scale = `ACST_FULL_SCALE_8G;
    endcase
  endfunction : full_scale

  // one-hot register select; all zero marks an unmapped address.
  // only the exact word address hits, so no alias can reach a register
  function automatic logic [`ACST_SEL_W-1:0] reg_decode(
    input logic [11:0] a
  );
    reg_decode = '0;
    case (a)
      `ACST_OFF_FILTER_CONTROL: reg_decode[`ACST_SEL_FILTER] = 1'b1;
      `ACST_OFF_POWER_CONTROL: reg_decode[`ACST_SEL_POWER] = 1'b1;
      `ACST_OFF_DIAG_CONTROL: reg_decode[`ACST_SEL_DIAG] = 1'b1;
      `ACST_OFF_STATUS: reg_decode[`ACST_SEL_STATUS] = 1'b1;
      `ACST_OFF_STIM_LEVEL: reg_decode[`ACST_SEL_STIM] = 1'b1;
      default: reg_decode = '0;
    endcase
  endfunction : reg_decode

  assign ext_sel = power_control_register_q[`ACST_BIT_EXTERNAL_CLOCK_SELECT];
  assign diag_on = diag_control_q[`ACST_BIT_DIAG_EN];
  assign sel = reg_decode(apb_req.paddr);
  // first access cycle raises pready: one wait state on every transfer
  assign access = apb_req.psel && apb_req.penable && !pready_q;
  // a write lands only at the edge where the master sees pready high,
  // so a request that is dropped early never changes a register
  assign done = apb_req.psel && apb_req.penable && pready_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_control_register_q <= `ACST_RST_REG8;
      diag_control_q <= `ACST_RST_REG8;
      filter_control_register_q <= `ACST_RST_REG8;
      stim_level_q <= STIM_RESET;
    end else if (clk_en && done && apb_req.pwrite) begin
      if (sel[`ACST_SEL_POWER]) begin
        power_control_register_q <= apb_req.pwdata[7:0]; // [RL2]
      end
      if (sel[`ACST_SEL_DIAG]) begin
        diag_control_q <= apb_req.pwdata[7:0]; // [RL4]
      end
      if (sel[`ACST_SEL_FILTER]) begin
        filter_control_register_q <= apb_req.pwdata[7:0];
      end
      if (sel[`ACST_SEL_STIM]) begin
        stim_level_q <= apb_req.pwdata[11:0];
      end
    end
  end

  // read data is captured on the first access cycle and stands for the
  // single cycle in which pready is high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= 32'h0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (clk_en) begin
      pready_q <= access;
      // unmapped addresses answer with an error; the status word is
      // read-only, so a write to it is dropped without one
      pslverr_q <= access && (sel == '0);
      prdata_q <= 32'h0;
      if (access && !apb_req.pwrite) begin
        if (sel[`ACST_SEL_POWER]) begin
          prdata_q <= {24'h0, power_control_register_q};
        end
        if (sel[`ACST_SEL_DIAG]) begin
          prdata_q <= {24'h0, diag_control_q};
        end
        if (sel[`ACST_SEL_FILTER]) begin
          prdata_q <= {24'h0, filter_control_register_q};
        end
        if (sel[`ACST_SEL_STATUS]) begin
          prdata_q <= {29'h0, data_valid, stimulus_on, use_external_clock};
        end
        if (sel[`ACST_SEL_STIM]) begin
          prdata_q <= {20'h0, stim_level_q};
        end
      end
    end
  end

  assign apb_rsp.prdata = prdata_q;
  assign apb_rsp.pready = pready_q;
  assign apb_rsp.pslverr = pslverr_q;

  // pin and clock source follow the select bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      use_external_clock <= 1'b0;
      first_interrupt_pin_oe_n <= 1'b0;
      first_interrupt_pin_out <= 1'b0;
      sample_clock <= 1'b0;
    end else if (clk_en) begin
      use_external_clock <= ext_sel; // [RL1]
      first_interrupt_pin_oe_n <= ext_sel; // [RL2]
      // never signal interrupts while the pin is an input
      first_interrupt_pin_out <= irq_request && !ext_sel; // [RL13]
      // plain sampling: the 51.2 kHz ceiling keeps it well under clk
      sample_clock <= ext_sel ? first_interrupt_pin_in : 1'b0; // [RL3]
    end
  end

  // stimulus offset added to axes; y sees it negative
  assign fs_sel = full_scale(
    filter_control_register_q[`ACST_BIT_RANGE_HI:`ACST_BIT_RANGE_LO]);
  assign stim_pos = diag_on ? stim_level_q : 12'h0; // [RL4]
  assign stim_neg = diag_on ? -stim_level_q : 12'h0; // [RL4]
  assign raw_flat = raw_axes;
  for (genvar i = 0; i < N_AXES; i++) begin : g_axis
    assign axis_sum[i] = sat_add(raw_flat[i*AXIS_W +: AXIS_W],
      (i == NEG_AXIS) ? stim_neg : stim_pos, fs_sel); // [RL12]
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stimulus_on <= 1'b0;
      data_axes <= '0;
      data_valid <= 1'b0;
    end else if (clk_en) begin
      stimulus_on <= diag_on; // [RL4]
      data_valid <= raw_valid;
      if (raw_valid) begin
        data_axes <= {axis_sum[2], axis_sum[1], axis_sum[0]}; // [RL12]
      end
    end
  end
endmodule : acst_self_test
`default_nettype wire

// [sim/acst_self_test_assertions.sv]
// port-level checker for the self-test and clock-select block
`timescale 1ns/1ps
`default_nettype none
`include "acst_cfg.svh"
module acst_self_test_assertions (
  input wire logic clk,
  input wire logic rst_n,
  input wire acst_pkg::acst_apb_req_t apb_req,
  input wire acst_pkg::acst_apb_rsp_t apb_rsp,
  input wire logic irq_request,
  input wire logic first_interrupt_pin_out,
  input wire logic first_interrupt_pin_oe_n,
  input wire logic sample_clock,
  input wire logic use_external_clock,
  input wire logic stimulus_on
);
  import acst_pkg::*;
  logic acc;
  logic ext;
  logic hit;
  logic wr;
  assign acc = apb_req.psel && apb_req.penable;
  assign ext = use_external_clock;
  assign wr = acc && apb_rsp.pready && apb_req.pwrite;
  assign hit = apb_req.paddr inside {`ACST_OFF_FILTER_CONTROL,
    `ACST_OFF_POWER_CONTROL, `ACST_OFF_DIAG_CONTROL, `ACST_OFF_STATUS,
    `ACST_OFF_STIM_LEVEL};
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  AST_ONE_WAIT: assert property (acc && !apb_rsp.pready |=> apb_rsp.pready)
    else $error("pready not one cycle after access");
  AST_PULSE: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready held longer than one cycle");
  AST_ERR: assert property (apb_rsp.pready |-> apb_rsp.pslverr == !hit)
    else $error("pslverr does not match address decode");
  AST_EXT_WR: assert property (
    wr && apb_req.paddr == `ACST_OFF_POWER_CONTROL |-> ##2
    ext == $past(apb_req.pwdata[`ACST_BIT_EXTERNAL_CLOCK_SELECT], 2))
    else $error("clock select did not follow write");
  AST_ST_WR: assert property (
    wr && apb_req.paddr == `ACST_OFF_DIAG_CONTROL |-> ##2
    stimulus_on == $past(apb_req.pwdata[`ACST_BIT_DIAG_EN], 2))
    else $error("stimulus did not follow write");
  AST_OE: assert property (ext && $past(ext) |-> first_interrupt_pin_oe_n)
    else $error("pin driven while used as clock input");
  AST_NO_IRQ: assert property (ext && $past(ext) |-> !first_interrupt_pin_out)
    else $error("interrupt shown on clock input pin");
  AST_IRQ: assert property (!ext && !$past(ext) |->
    first_interrupt_pin_out == $past(irq_request) && !sample_clock)
    else $error("internal clock mode pin behaviour wrong");
endmodule : acst_self_test_assertions
`default_nettype wire

// [sim/acst_host_model.sv]
// host apb master model
`timescale 1ns/1ps
`default_nettype none
module acst_host_model (
  input wire logic clk,
  output var acst_pkg::acst_apb_req_t apb_req,
  input wire acst_pkg::acst_apb_rsp_t apb_rsp
);
  import acst_pkg::*;
  initial apb_req = '0;
  // waits without limit; the bench timeout cuts a hang
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge clk);
    apb_req <= '{a, 1'b1, 1'b0, w, d};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    do @(posedge clk); while (apb_rsp.pready !== 1'b1);
    q = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    apb_req <= '0;
  endtask : xfer
endmodule : acst_host_model
`default_nettype wire

// [sim/tb.sv]
// self-checking bench for the self-test block
`timescale 1ns/1ps
`default_nettype none
`include "acst_cfg.svh"
module tb;
  import acst_pkg::*;
  logic clk, rst_n, raw_valid, irq_request, host_clk, pin_in, pin_out;
  logic pin_oe_n, sample_clock, use_ext, stim_on, data_valid, e;
  logic [31:0] q;
  acst_apb_req_t apb_req;
  acst_apb_rsp_t apb_rsp;
  acst_axes_t raw_axes, data_axes;
  int n_fail = 0, total_checks = 0, cyc = 0;
  // pin level from both drivers
  assign pin_in = pin_oe_n ? host_clk : pin_out;
  acst_self_test acst_self_test_i (.clk(clk), .rst_n(rst_n), .clk_en(1'b1),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .raw_axes(raw_axes),
    .raw_valid(raw_valid), .irq_request(irq_request),
    .first_interrupt_pin_in(pin_in), .first_interrupt_pin_out(pin_out),
    .first_interrupt_pin_oe_n(pin_oe_n), .sample_clock(sample_clock),
    .use_external_clock(use_ext), .stimulus_on(stim_on),
    .data_axes(data_axes), .data_valid(data_valid));
  acst_host_model acst_host_model_i (.clk(clk), .apb_req(apb_req),
    .apb_rsp(apb_rsp));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    acst_host_model_i.xfer(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [35:0] x);
    acst_host_model_i.xfer(1'b0, a, 32'h0, q, e);
    chk({3'h0, e, q}, x);
  endtask : rd
  task automatic axes(input acst_axes_t r, input acst_axes_t x);
    @(posedge clk);
    raw_axes <= r;
    raw_valid <= 1'b1;
    @(posedge clk);
    raw_valid <= 1'b0;
    repeat (3) begin
      #1;
      if (data_valid === 1'b1) break;
      @(posedge clk);
    end
    chk(data_valid, 1'b1);
    chk(data_axes, x);
  endtask : axes
  task automatic t_regs();
    rd(`ACST_OFF_POWER_CONTROL, 36'h0);
    rd(`ACST_OFF_DIAG_CONTROL, 36'h0);
    rd(`ACST_OFF_FILTER_CONTROL, 36'h0);
    rd(`ACST_OFF_STATUS, 36'h0);
    rd(`ACST_OFF_STIM_LEVEL, {24'h0, `ACST_RST_STIM});
    wr(12'h100, 32'hff);
    chk(e, 1'b1);
    rd(12'h100, 36'h100000000);
  endtask : t_regs
  task automatic t_clk();
    irq_request <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk({pin_out, pin_oe_n, sample_clock}, 3'b100);
    wr(`ACST_OFF_POWER_CONTROL, 32'h40);
    rd(`ACST_OFF_POWER_CONTROL, 36'h40);
    rd(`ACST_OFF_STATUS, 36'h1);
    // half period of 1000 cycles: 50 kHz, inside the pin clock ceiling
    repeat (2) begin
      @(posedge clk);
      host_clk <= ~host_clk;
      repeat (3) @(posedge clk);
      #1;
      chk({use_ext, pin_oe_n, pin_out}, 3'b110);
      chk(sample_clock, host_clk);
      repeat (996) @(posedge clk);
    end
    wr(`ACST_OFF_POWER_CONTROL, 32'h0);
    repeat (3) @(posedge clk);
    #1;
    chk({use_ext, pin_oe_n, pin_out, sample_clock}, 4'b0010);
  endtask : t_clk
  task automatic t_st();
    wr(`ACST_OFF_FILTER_CONTROL, 32'h80);
    axes('{12'h064, 12'h064, 12'h064}, '{12'h064, 12'h064, 12'h064});
    wr(`ACST_OFF_DIAG_CONTROL, 32'h1);
    @(posedge clk);
    #1;
    chk(stim_on, 1'b1);
    // four samples cover the settling time; each is checked alone, none averaged; delta 250 lsb
    repeat (4) axes('{12'h064, 12'h064, 12'h064},
      '{12'h15e, 12'hf6a, 12'h15e});
    axes('{12'h7f0, 12'h000, 12'h7f0}, '{12'h7ff, 12'hf06, 12'h7ff});
    wr(`ACST_OFF_DIAG_CONTROL, 32'h0);
    @(posedge clk);
    #1;
    chk(stim_on, 1'b0);
    axes('{12'h064, 12'h064, 12'h064}, '{12'h064, 12'h064, 12'h064});
  endtask : t_st
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    rst_n = 0;
    raw_valid = 0;
    irq_request = 0;
    host_clk = 0;
    raw_axes = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_clk();
    t_st();
    summarize();
  end
endmodule : tb
bind acst_self_test acst_self_test_assertions acst_self_test_assertions_i (
  .clk(clk), .rst_n(rst_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .irq_request(irq_request), .first_interrupt_pin_out(first_interrupt_pin_out),
  .first_interrupt_pin_oe_n(first_interrupt_pin_oe_n),
  .sample_clock(sample_clock), .use_external_clock(use_external_clock),
  .stimulus_on(stimulus_on));
`default_nettype wire
